// [hw/psp_switch_points.sv]
// position switching point unit: four points, two slots per driving set
`timescale 1ns/100ps
// widths, selector limits and reset values
`include "psp_cfg.svh"

// Behaviour
// - four switching points 0..3, each with own position, mode, actions
// - a tripping point applies its own action to each of three flags
// - any driving set may select any point; points are shared
// - at most two points, chosen by the running set, are evaluated
// - slot A and B selectors take 0..4; zero disables the slot
// - point target is a signed 32-bit value read per mode and set
// - mode 0 trips when actual position reaches the absolute target
// - mode 1 trips after travelling the distance from set start
// - mode 2 trips the distance before the set end position
module psp_switch_points
  import psp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // per point settings, read live every cycle; the slot A and B selectors are sampled only at set start
  input wire logic [`PSP_NUM_POINTS-1:0][`PSP_POS_W-1:0]
    i_point_target_position,
  input wire logic [`PSP_NUM_POINTS-1:0][1:0] i_point_reference_mode,
  input wire logic [`PSP_NUM_POINTS-1:0][1:0] i_flag_one_action,
  input wire logic [`PSP_NUM_POINTS-1:0][1:0] i_flag_two_action,
  input wire logic [`PSP_NUM_POINTS-1:0][1:0] i_flag_three_action,
  input wire logic [`PSP_SEL_W-1:0] i_set_point_slot_a,
  input wire logic [`PSP_SEL_W-1:0] i_set_point_slot_b,
  // running driving set from the profile generator
  input wire logic i_set_start,
  input wire logic i_set_running,
  input wire logic [`PSP_POS_W-1:0] i_act_position,
  input wire logic [`PSP_POS_W-1:0] i_set_start_position,
  input wire logic [`PSP_POS_W-1:0] i_set_end_position,
  // flag levels and one-cycle trip pulses
  output logic o_output_flag_one,
  output logic o_output_flag_two,
  output logic o_output_flag_three,
  output logic o_slot_a_tripped,
  output logic o_slot_b_tripped
);

  // selector 1..4 maps to point 0..3; 5..7 are treated like 0
  // since they name no point at all
  function automatic logic sel_on(input psp_sel_t sel);
    sel_on = (sel != `PSP_SEL_OFF) && (sel <= `PSP_SEL_MAX);
  endfunction

  // point index of a selector, only meaningful while sel_on holds
  function automatic psp_idx_t sel_idx(input psp_sel_t sel);
    psp_sel_t m1;
    m1 = sel - 3'h1;
    sel_idx = m1[`PSP_IDX_W-1:0];
  endfunction

  // one flag under one action code
  function automatic logic flag_apply(input logic f, input logic [1:0] a);
    logic r;
    r = f;
    unique case (a)
      2'(flag_keep): r = f;
      2'(flag_set): r = 1'b1;
      2'(flag_clear): r = 1'b0;
      2'(flag_toggle): r = ~f;
    endcase
    return r;
  endfunction

  // slot selection captured at set start, so edits mid-set do no harm
  psp_sel_t sel_a_ff;
  psp_sel_t sel_b_ff;
  psp_sel_t nxt_sel_a;
  psp_sel_t nxt_sel_b;
  // once-per-set bookkeeping
  logic fired_a_ff;
  logic fired_b_ff;
  logic nxt_fired_a;
  logic nxt_fired_b;
  // flag state and trip pulses
  logic [2:0] flags_ff;
  logic [2:0] nxt_flags;
  logic trip_a_ff;
  logic trip_b_ff;
  logic nxt_trip_a;
  logic nxt_trip_b;

  // per-slot point index and trip condition
  psp_idx_t idx_a;
  psp_idx_t idx_b;
  logic trip_a;
  logic trip_b;

  // one carrier per slot evaluator
  psp_slot_if slot_a ();
  psp_slot_if slot_b ();

  // route the selected point's settings to each slot evaluator;
  // a disabled slot still routes some point but never trips
  always_comb
  begin
    idx_a = sel_idx(sel_a_ff);
    idx_b = sel_idx(sel_b_ff);
    slot_a.target = i_point_target_position[idx_a];
    slot_a.ref_mode = i_point_reference_mode[idx_a];
    slot_a.act_pos = i_act_position;
    slot_a.start_pos = i_set_start_position;
    slot_a.end_pos = i_set_end_position;
    slot_b.target = i_point_target_position[idx_b];
    slot_b.ref_mode = i_point_reference_mode[idx_b];
    slot_b.act_pos = i_act_position;
    slot_b.start_pos = i_set_start_position;
    slot_b.end_pos = i_set_end_position;
  end

  // only two evaluators exist, so no more than two points can act
  psp_slot_eval u_eval_a
  (
    .s(slot_a.eval)
  );

  psp_slot_eval u_eval_b
  (
    .s(slot_b.eval)
  );

  // first trip of an armed slot; start cycle itself never trips,
  // so a stale reach result from the last set cannot act
  always_comb
  begin
    trip_a = i_set_running && !i_set_start && sel_on(sel_a_ff)
      && !fired_a_ff && slot_a.reached;
    trip_b = i_set_running && !i_set_start && sel_on(sel_b_ff)
      && !fired_b_ff && slot_b.reached;
  end

  // selection and once-per-set bookkeeping; a start re-arms both
  // slots, and no trip can fall in that same cycle
  always_comb
  begin
    nxt_sel_a = sel_a_ff;
    nxt_sel_b = sel_b_ff;
    nxt_fired_a = fired_a_ff | trip_a;
    nxt_fired_b = fired_b_ff | trip_b;
    if (i_set_start)
    begin
      nxt_sel_a = i_set_point_slot_a;
      nxt_sel_b = i_set_point_slot_b;
      nxt_fired_a = 1'b0;
      nxt_fired_b = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // slots leave reset disabled
      sel_a_ff <= `PSP_SEL_RST;
      sel_b_ff <= `PSP_SEL_RST;
      fired_a_ff <= 1'b0;
      fired_b_ff <= 1'b0;
    end
    else
    begin
      sel_a_ff <= nxt_sel_a;
      sel_b_ff <= nxt_sel_b;
      fired_a_ff <= nxt_fired_a;
      fired_b_ff <= nxt_fired_b;
    end
  end

  // flag update: slot A first, then slot B on its result, so a
  // same-cycle trip of both composes instead of one being lost
  always_comb
  begin
    nxt_flags = flags_ff;
    // pulses registered so they line up with the flag change
    nxt_trip_a = trip_a;
    nxt_trip_b = trip_b;
    if (trip_a)
    begin
      nxt_flags[0] = flag_apply(nxt_flags[0], i_flag_one_action[idx_a]);
      nxt_flags[1] = flag_apply(nxt_flags[1], i_flag_two_action[idx_a]);
      nxt_flags[2] = flag_apply(nxt_flags[2],
        i_flag_three_action[idx_a]);
    end
    if (trip_b)
    begin
      nxt_flags[0] = flag_apply(nxt_flags[0], i_flag_one_action[idx_b]);
      nxt_flags[1] = flag_apply(nxt_flags[1], i_flag_two_action[idx_b]);
      nxt_flags[2] = flag_apply(nxt_flags[2],
        i_flag_three_action[idx_b]);
    end
  end

  // flags persist across sets; only reset or a trip action changes them
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      // flags leave reset low
      flags_ff <= {3{`PSP_FLAG_RST}};
      trip_a_ff <= 1'b0;
      trip_b_ff <= 1'b0;
    end
    else
    begin
      flags_ff <= nxt_flags;
      trip_a_ff <= nxt_trip_a;
      trip_b_ff <= nxt_trip_b;
    end
  end

  // outputs straight from flops, so users see no glitch from the
  // reach comparators
  assign o_output_flag_one = flags_ff[0];
  assign o_output_flag_two = flags_ff[1];
  assign o_output_flag_three = flags_ff[2];
  assign o_slot_a_tripped = trip_a_ff;
  assign o_slot_b_tripped = trip_b_ff;

endmodule

// [hw/psp_cfg.svh]
// constants of the position switching point unit
`ifndef PSP_CFG_SVH
`define PSP_CFG_SVH

// number of switching points and their index width
`define PSP_NUM_POINTS 4
`define PSP_IDX_W 2
// driving set slot selector width, 0 disables, 1..4 pick point 0..3
`define PSP_SEL_W 3
`define PSP_SEL_OFF 3'h0
`define PSP_SEL_MAX 3'h4
// position width, signed
`define PSP_POS_W 32
// reset values
`define PSP_FLAG_RST 1'b0
`define PSP_SEL_RST 3'h0

`endif

// [hw/psp_pkg.sv]
// types of the position switching point unit
`include "psp_cfg.svh"

package psp_pkg;

  typedef logic signed [`PSP_POS_W-1:0] psp_pos_t;
  typedef logic [`PSP_SEL_W-1:0] psp_sel_t;
  typedef logic [`PSP_IDX_W-1:0] psp_idx_t;

  // reference mode of a point, bus codes 0..2; code 3 is illegal
  typedef enum logic [1:0] {
    mode_absolute,
    mode_from_start,
    mode_before_end
  } psp_ref_e;

  // flag action, bus codes 0..3
  typedef enum logic [1:0] {
    flag_keep,
    flag_set,
    flag_clear,
    flag_toggle
  } psp_act_e;

endpackage

// [hw/psp_slot_if.sv]
// carrier between the unit and one slot evaluator
`timescale 1ns/100ps

interface psp_slot_if;
  import psp_pkg::*;

  psp_pos_t target;
  logic [1:0] ref_mode;
  psp_pos_t act_pos;
  psp_pos_t start_pos;
  psp_pos_t end_pos;
  logic reached;

  modport drv
  (
    output target,
    output ref_mode,
    output act_pos,
    output start_pos,
    output end_pos,
    input reached
  );

  modport eval
  (
    input target,
    input ref_mode,
    input act_pos,
    input start_pos,
    input end_pos,
    output reached
  );
endinterface

// [hw/psp_slot_eval.sv]
// trip threshold and reach test for one switching point slot
`timescale 1ns/100ps
`include "psp_cfg.svh"

module psp_slot_eval
  import psp_pkg::*;
(
  psp_slot_if.eval s
);

  // 33 bits so start+distance cannot wrap around
  logic signed [`PSP_POS_W:0] thr;
  logic signed [`PSP_POS_W:0] act_x;
  logic signed [`PSP_POS_W:0] start_x;
  logic signed [`PSP_POS_W:0] end_x;
  logic signed [`PSP_POS_W:0] tgt_x;
  logic fwd;
  logic legal;

  // threshold from mode, direction from the set's start and end
  always_comb
  begin
    act_x = {s.act_pos[`PSP_POS_W-1], s.act_pos};
    start_x = {s.start_pos[`PSP_POS_W-1], s.start_pos};
    end_x = {s.end_pos[`PSP_POS_W-1], s.end_pos};
    tgt_x = {s.target[`PSP_POS_W-1], s.target};
    fwd = (s.end_pos >= s.start_pos);
    legal = 1'b1;
    thr = tgt_x;
    unique case (s.ref_mode)
      2'(mode_absolute):
        thr = tgt_x;
      2'(mode_from_start):
        thr = fwd ? start_x + tgt_x : start_x - tgt_x;
      2'(mode_before_end):
        thr = fwd ? end_x - tgt_x : end_x + tgt_x;
      default:
        legal = 1'b0; // illegal mode code never trips
    endcase
    // reached means at or past the threshold in the travel direction
    s.reached = legal && (fwd ? (act_x >= thr) : (act_x <= thr));
  end

endmodule

// [dv/psp_sp_properties.sv]
// concurrent checks on the switching point unit ports
`timescale 1ns/100ps

module psp_sp_properties
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_set_start,
  input wire logic i_set_running,
  input wire logic [2:0] i_set_point_slot_a,
  input wire logic o_output_flag_one,
  input wire logic o_output_flag_two,
  input wire logic o_output_flag_three,
  input wire logic o_slot_a_tripped,
  input wire logic o_slot_b_tripped
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // a start edge re-arms only, it never trips
  property p_start_no_trip;
    i_set_start |=> !o_slot_a_tripped && !o_slot_b_tripped;
  endproperty
  a_start_no_trip: assert property (p_start_no_trip)
    else $error("trip pulse after a start edge");
  // no evaluation while the set is idle
  property p_idle_no_trip;
    !i_set_running |=> !o_slot_a_tripped && !o_slot_b_tripped;
  endproperty
  a_idle_no_trip: assert property (p_idle_no_trip)
    else $error("trip pulse while not running");
  // a restart right after a trip may legally re-arm the slot
  property p_a_once;
    o_slot_a_tripped && !i_set_start |=> !o_slot_a_tripped [*2];
  endproperty
  a_a_once: assert property (p_a_once)
    else $error("slot a tripped twice");
  property p_b_once;
    o_slot_b_tripped && !i_set_start |=> !o_slot_b_tripped [*2];
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("slot b tripped twice");
  // flags move only together with a trip pulse
  property p_flag1_cause;
    !$stable(o_output_flag_one) |-> o_slot_a_tripped || o_slot_b_tripped;
  endproperty
  a_flag1_cause: assert property (p_flag1_cause)
    else $error("flag one changed without a trip");
  property p_flag2_cause;
    !$stable(o_output_flag_two) |-> o_slot_a_tripped || o_slot_b_tripped;
  endproperty
  a_flag2_cause: assert property (p_flag2_cause)
    else $error("flag two changed without a trip");
  property p_flag3_cause;
    $changed(o_output_flag_three) |-> $rose(o_slot_a_tripped) ||
      $rose(o_slot_b_tripped);
  endproperty
  a_flag3_cause: assert property (p_flag3_cause)
    else $error("flag three changed without a trip");
  // selector zero keeps slot a silent for the three cycles after the start, unless restarted
  property p_off_slot_a;
    i_set_start && i_set_point_slot_a == 3'h0 ##1 !i_set_start |->
      !o_slot_a_tripped [*3];
  endproperty
  a_off_slot_a: assert property (p_off_slot_a)
    else $error("disabled slot a tripped");
endmodule

bind psp_switch_points psp_sp_properties i_psp_sp_properties (.*);

// [dv/psp_motion_model.sv]
// motion profile generator stand-in: one linear driving set per go pulse
`timescale 1ns/100ps

module psp_motion_model
(
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [31:0] i_from,
  input wire logic [31:0] i_to,
  input wire logic [31:0] i_step,
  output logic o_set_start,
  output logic o_set_running,
  output logic [31:0] o_act,
  output logic [31:0] o_start,
  output logic [31:0] o_end
);
  initial
  begin
    o_set_start = 1'b0;
    o_set_running = 1'b0;
    o_act = 32'h0;
    o_start = 32'h0;
    o_end = 32'h0;
  end
  // step must divide the travel, else the set never ends
  always @(posedge i_mclk)
  begin
    o_set_start <= i_go;
    o_set_running <= o_set_start || (o_set_running && o_act != o_end);
    if (i_go)
    begin
      o_act <= i_from;
      o_start <= i_from;
      o_end <= i_to;
    end
    else if (o_set_running && o_act != o_end)
      o_act <= o_act + i_step;
  end
endmodule

// [dv/position_switching_points_bench.sv]
// self-checking bench of the switching point unit
`timescale 1ns/100ps

module position_switching_points_bench
  import psp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic [31:0] from = 32'h0, to = 32'h0, step = 32'h0;
  logic [3:0][31:0] tgt = '0;
  logic [3:0][1:0] md = '0, a1 = '0, a2 = '0, a3 = '0;
  logic [2:0] sa = 3'h0, sb = 3'h0;
  logic st, run_l, f1, f2, f3, ta, tb;
  logic [31:0] act, sp, ep;
  int fail_count = 0, num_checks = 0, ca = 0, cb = 0;
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    ca += ta;
    cb += tb;
  end
  psp_motion_model i_psp_motion_model (.i_mclk(clk), .i_go(go),
    .i_from(from), .i_to(to), .i_step(step), .o_set_start(st),
    .o_set_running(run_l), .o_act(act), .o_start(sp), .o_end(ep));
  psp_switch_points i_psp_switch_points (.i_mclk(clk), .i_sys_rst(rst),
    .i_point_target_position(tgt), .i_point_reference_mode(md),
    .i_flag_one_action(a1), .i_flag_two_action(a2),
    .i_flag_three_action(a3), .i_set_point_slot_a(sa),
    .i_set_point_slot_b(sb), .i_set_start(st), .i_set_running(run_l),
    .i_act_position(act), .i_set_start_position(sp),
    .i_set_end_position(ep), .o_output_flag_one(f1),
    .o_output_flag_two(f2), .o_output_flag_three(f3),
    .o_slot_a_tripped(ta), .o_slot_b_tripped(tb));
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic cfg(input int p, input logic [31:0] t,
    input logic [1:0] m, x, y, z);
    @(posedge clk);
    tgt[p] <= t;
    md[p] <= m;
    a1[p] <= x;
    a2[p] <= y;
    a3[p] <= z;
  endtask
  // one set, waited out with a bound so a stuck model cannot hang
  task automatic drive(input logic [2:0] a, b, input logic [31:0] f, t, s);
    int n;
    n = 0;
    @(posedge clk);
    sa <= a;
    sb <= b;
    from <= f;
    to <= t;
    step <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(negedge clk);
    while (run_l && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    chk("set running", 32'h0, run_l);
    repeat (2) @(negedge clk);
  endtask
  task automatic s_abs;
    cfg(0, 32'h64, mode_absolute, flag_set, flag_toggle, flag_keep);
    drive(3'h1, 3'h0, 32'h0, 32'hc8, 32'ha);
    chk("flag one", 32'h1, f1);
    chk("flag two", 32'h1, f2);
    chk("flag three", 32'h0, f3);
    chk("trips a", 32'h1, ca);
    $display("s_abs done");
  endtask
  task automatic s_modes;
    cfg(1, 32'h32, mode_from_start, flag_clear, flag_keep, flag_keep);
    cfg(2, 32'h1e, mode_before_end, flag_keep, flag_keep, flag_set);
    drive(3'h2, 3'h3, 32'h3e8, 32'h384, 32'hfffffff6);
    chk("flag one", 32'h0, f1);
    chk("flag three", 32'h1, f3);
    chk("trips b", 32'h1, cb);
    $display("s_modes done");
  endtask
  task automatic s_shared;
    cfg(3, 32'h80000000, mode_absolute, flag_keep, flag_toggle, flag_keep);
    drive(3'h4, 3'h4, 32'h0, 32'h64, 32'ha);
    chk("flag two", 32'h1, f2);
    chk("trips a", 32'h3, ca);
    chk("trips b", 32'h2, cb);
    $display("s_shared done");
  endtask
  task automatic s_off;
    drive(3'h0, 3'h5, 32'h0, 32'hc8, 32'ha);
    chk("trips a", 32'h3, ca);
    chk("trips b", 32'h2, cb);
    $display("s_off done");
  endtask
  // mode code 3 names no reference, so the point must stay silent
  task automatic s_illegal;
    cfg(0, 32'h64, 2'h3, flag_toggle, flag_toggle, flag_toggle);
    drive(3'h1, 3'h1, 32'h0, 32'hc8, 32'ha);
    chk("flag one", 32'h0, f1);
    chk("flag two", 32'h1, f2);
    chk("flag three", 32'h1, f3);
    chk("trips a", 32'h3, ca);
    chk("trips b", 32'h2, cb);
    $display("s_illegal done");
  endtask
  // reset between sets clears the flags; a set right after release works
  task automatic s_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("flag two", 32'h0, f2);
    chk("flag three", 32'h0, f3);
    cfg(0, 32'h64, mode_absolute, flag_set, flag_keep, flag_keep);
    drive(3'h1, 3'h0, 32'h0, 32'hc8, 32'ha);
    chk("flag one", 32'h1, f1);
    chk("flag two", 32'h0, f2);
    chk("trips a", 32'h4, ca);
    chk("trips b", 32'h2, cb);
    $display("s_reset done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    s_abs();
    s_modes();
    s_shared();
    s_off();
    s_illegal();
    s_reset();
    print_verdict();
  end
  // watchdog well past the roughly 150 cycles the sets need
  initial
  begin
    #20000;
    fail_count++;
    print_verdict();
  end
endmodule
